/* hdl/fecs_pkg.sv */
// Constants shared by both ends of the flash erase command sequencer.
// Assumes a 16-bit word bus and one system clock for both ends.
package fecs_pkg;
	// ************************************************************
	// Array geometry
	// ************************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BANK_W = 1;
	localparam int SPB_W = 2; // Sectors per bank, log2
	localparam int WORD_W = 2; // Words per sector, log2
	localparam int SECT_W = BANK_W + SPB_W;
	localparam int NUM_SECT = 1 << SECT_W;
	localparam int NUM_WORDS = 1 << (SECT_W + WORD_W);
	// ************************************************************
	// Command codes and unlock offsets
	// ************************************************************
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_SETUP = 16'h0080;
	localparam logic [15:0] CMD_SECTOR = 16'h0030;
	localparam logic [15:0] CMD_CHIP = 16'h0010;
	localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [15:0] CMD_RESUME = 16'h0030;
	localparam logic [15:0] CMD_READ_RESET = 16'h00F0;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [15:0] PREPROG_WORD = 16'h0000;
	localparam logic [11:0] WORD_OFS_A = 12'h555;
	localparam logic [11:0] WORD_OFS_B = 12'h2AA;
	localparam logic [11:0] BYTE_OFS_A = 12'hAAA;
	localparam logic [11:0] BYTE_OFS_B = 12'h554;
	// ************************************************************
	// Status bit positions
	// ************************************************************
	localparam int DP_BIT = 7; // data_polarity_flag
	localparam int TOG_BIT = 6; // toggle_flag
	localparam int WIN_BIT = 3; // erase_window_flag
	localparam int STOG_BIT = 2; // sector_toggle_flag
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 125;
	localparam int ERASE_ACCEPT_WINDOW_US = 50;
	localparam int ERASE_ACCEPT_WINDOW_CYC = ERASE_ACCEPT_WINDOW_US * CLK_MHZ;
	localparam int STEP_CYC = 4; // Cycles spent per location in the erase walk
	// ************************************************************
	// Host register map and operations
	// ************************************************************
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_ADDR = 12'h004;
	localparam logic [11:0] REG_CFG = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam int CFG_BYTE_BIT = 0;
	localparam int CFG_HWRST_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DATA_LSB = 16;
	localparam logic [2:0] OP_SECTOR = 3'h1;
	localparam logic [2:0] OP_CHIP = 3'h2;
	localparam logic [2:0] OP_ADD = 3'h3;
	localparam logic [2:0] OP_SUSPEND = 3'h4;
	localparam logic [2:0] OP_RESUME = 3'h5;
	localparam logic [2:0] OP_READ = 3'h6;
	localparam logic [2:0] OP_RESET_CMD = 3'h7;
	localparam logic [2:0] SEQ_LEN = 3'h6;
endpackage : fecs_pkg

/* hdl/fecs_if.sv */
// Bus between the host end and the flash erase sequencer end.
// Both ends run on the same clock; all signals are synchronous to it.
`timescale 1ns/10ps
interface fecs_if;
	logic we_n; // Write strobe, active low
	logic oe_n; // Read strobe, active low
	logic [15:0] addr; // Word or byte address
	logic [15:0] wdata; // Write data
	logic [15:0] rdata; // Read data
	logic byte_mode; // High selects byte addressing
	logic hw_reset_n; // Hardware reset, active low
	modport device (input we_n, input oe_n, input addr, input wdata, output rdata,
		input byte_mode, input hw_reset_n);
	modport host (output we_n, output oe_n, output addr, output wdata, input rdata,
		output byte_mode, output hw_reset_n);
endinterface : fecs_if

/* hdl/fecs_device.sv */
// Flash erase command sequencer: decodes unlock/erase writes, runs the
// accept window and the preprogram-then-erase walk, reports status on reads.
// Assumes link inputs are synchronous to clk_sys_in.
`timescale 1ns/10ps
module fecs_device
	import fecs_pkg::*;
#(
	parameter int WINDOW_CYC = ERASE_ACCEPT_WINDOW_CYC,
	parameter int STEP_CYCLES = STEP_CYC
) (
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	fecs_if.device link, // Flash bus
	output logic busy_out, // Erase window or walk active
	output logic suspended_out // Erase is suspended
);
	// ************************************************************
	// Types and state
	// ************************************************************
	typedef enum {
		ST_READ, ST_UL1, ST_UL2, ST_SETUP, ST_UL4, ST_UL5,
		ST_WINDOW, ST_PREPROG, ST_ERASE, ST_SUSP
	} fecs_state_t;

	localparam int IDX_W = SECT_W + WORD_W;
	fecs_state_t state;
	logic we_q, oe_q;
	logic [NUM_SECT-1:0] queued;
	logic chip;
	logic [BANK_W-1:0] er_bank;
	logic susp_erase; // Walk phase to resume into
	logic [31:0] win_cnt;
	logic [31:0] step_cnt;
	logic [IDX_W-1:0] ptr;
	logic [DATA_W-1:0] mem [NUM_WORDS];
	logic tog, stog;
	logic [DATA_W-1:0] rdata_q;

	// ************************************************************
	// Decode
	// ************************************************************
	logic we_rise, oe_fall, abort, is_a, is_b, step_done, ptr_last;
	logic [ADDR_W-1:0] wa;
	logic [SECT_W-1:0] sect;
	logic [IDX_W-1:0] widx;
	logic [DATA_W-1:0] d;
	logic walking, status_sel;

	assign we_rise = !we_q && link.we_n; // Command taken at strobe rise
	assign oe_fall = oe_q && !link.oe_n;
	assign abort = rst_in || !link.hw_reset_n;
	assign wa = link.byte_mode ? {1'b0, link.addr[ADDR_W-1:1]} : link.addr;
	// Unlock offsets move with the addressing mode
	assign is_a = link.addr[11:0] == (link.byte_mode ? BYTE_OFS_A : WORD_OFS_A);
	assign is_b = link.addr[11:0] == (link.byte_mode ? BYTE_OFS_B : WORD_OFS_B);
	assign sect = wa[ADDR_W-1 -: SECT_W];
	assign widx = {sect, wa[WORD_W-1:0]};
	assign d = link.wdata;
	assign walking = state == ST_PREPROG || state == ST_ERASE;
	assign step_done = step_cnt == 32'(STEP_CYCLES - 1);
	assign ptr_last = ptr == IDX_W'(NUM_WORDS - 1);

	// Strobe edge history
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			we_q <= 1'b1;
			oe_q <= 1'b1;
		end else begin
			we_q <= link.we_n;
			oe_q <= link.oe_n;
		end
	end

	// ************************************************************
	// Command sequencer
	// ************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (abort) begin
			state <= ST_READ;
			queued <= '0;
			chip <= 1'b0;
			er_bank <= '0;
			susp_erase <= 1'b0;
			win_cnt <= '0;
		end else begin
			unique case (state)
				ST_READ: if (we_rise) begin
					state <= (d == CMD_UNLOCK1 && is_a) ? ST_UL1 : ST_READ;
				end
				ST_UL1: if (we_rise) begin
					state <= (d == CMD_UNLOCK2 && is_b) ? ST_UL2 : ST_READ;
				end
				ST_UL2: if (we_rise) begin
					state <= (d == CMD_SETUP && is_a) ? ST_SETUP : ST_READ;
				end
				ST_SETUP: if (we_rise) begin
					state <= (d == CMD_UNLOCK1 && is_a) ? ST_UL4 : ST_READ;
				end
				ST_UL4: if (we_rise) begin
					state <= (d == CMD_UNLOCK2 && is_b) ? ST_UL5 : ST_READ;
				end
				ST_UL5: if (we_rise) begin
					if (d == CMD_SECTOR) begin
						state <= ST_WINDOW;
						queued[sect] <= 1'b1;
						er_bank <= sect[SECT_W-1 -: BANK_W];
						win_cnt <= '0;
					end else if (d == CMD_CHIP && is_a) begin
						state <= ST_PREPROG;
						queued <= '1;
						chip <= 1'b1;
					end else begin
						state <= ST_READ;
					end
				end
				ST_WINDOW: begin
					if (we_rise) begin
						if (d == CMD_SECTOR) begin
							queued[sect] <= 1'b1;
							win_cnt <= '0; // Each added sector restarts the window
						end else if (d == CMD_SUSPEND) begin
							state <= ST_SUSP;
							susp_erase <= 1'b0;
						end else begin
							state <= ST_READ;
							queued <= '0;
						end
					end else if (win_cnt == 32'(WINDOW_CYC - 1)) begin
						state <= ST_PREPROG;
					end else begin
						win_cnt <= win_cnt + 32'd1;
					end
				end
				ST_PREPROG, ST_ERASE: begin
					// Only suspend counts, and only for sector erase
					if (we_rise && d == CMD_SUSPEND && !chip) begin
						state <= ST_SUSP;
						susp_erase <= state == ST_ERASE;
					end else if (step_done && ptr_last) begin
						if (state == ST_PREPROG) begin
							state <= ST_ERASE;
						end else begin
							state <= ST_READ;
							queued <= '0;
							chip <= 1'b0;
						end
					end
				end
				ST_SUSP: if (we_rise && d == CMD_RESUME) begin
					state <= susp_erase ? ST_ERASE : ST_PREPROG;
				end
			endcase
		end
	end

	// ************************************************************
	// Self-timed walk over the array
	// ************************************************************
	// Restarts at location zero on each phase; pauses while suspended
	always_ff @(posedge clk_sys_in) begin
		if (abort || !(walking || state == ST_SUSP)) begin
			step_cnt <= '0;
			ptr <= '0;
		end else if (walking) begin
			if (step_done) begin
				step_cnt <= '0;
				ptr <= ptr + IDX_W'(1);
			end else begin
				step_cnt <= step_cnt + 32'd1;
			end
		end
	end

	// Array storage; writes come only from the walk
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				mem[i] <= ERASED_WORD;
			end
		end else if (walking && step_done && queued[ptr[IDX_W-1 -: SECT_W]]) begin
			mem[ptr] <= (state == ST_PREPROG) ? PREPROG_WORD : ERASED_WORD;
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Status goes to the erasing bank; suspended bank shows array for unqueued sectors
	always_comb begin
		status_sel = 1'b0;
		if (state == ST_WINDOW || walking) begin
			status_sel = chip || sect[SECT_W-1 -: BANK_W] == er_bank;
		end else if (state == ST_SUSP) begin
			status_sel = queued[sect];
		end
	end

	// tog advances once per status read outside suspend; stog once per status read of a queued sector
	always_ff @(posedge clk_sys_in) begin
		if (abort) begin
			tog <= 1'b0;
			stog <= 1'b0;
		end else if (oe_fall && status_sel) begin
			if (state != ST_SUSP) begin
				tog <= !tog;
			end
			if (queued[sect]) begin
				stog <= !stog;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_q <= '0;
		end else if (!link.oe_n) begin
			if (status_sel) begin
				rdata_q <= '0;
				rdata_q[DP_BIT] <= state == ST_SUSP;
				rdata_q[TOG_BIT] <= tog;
				rdata_q[WIN_BIT] <= state != ST_WINDOW;
				rdata_q[STOG_BIT] <= stog;
			end else begin
				rdata_q <= mem[widx];
			end
		end
	end
	assign link.rdata = rdata_q;

	// User-side flags
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			busy_out <= 1'b0;
			suspended_out <= 1'b0;
		end else begin
			busy_out <= state == ST_WINDOW || walking;
			suspended_out <= state == ST_SUSP;
		end
	end
endmodule : fecs_device

/* hdl/fecs_host.sv */
// Host end: APB registers take erase orders and issue them as strobed
// writes and reads on the flash bus. Assumes one clock for APB and link.
`timescale 1ns/10ps
module fecs_host
	import fecs_pkg::*;
(
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB direction
	input wire logic [11:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error on unmapped address
	fecs_if.host link // Flash bus
);
	// ************************************************************
	// Registers and state
	// ************************************************************
	typedef enum {H_IDLE, H_WLOW, H_WHIGH, H_RLOW, H_RCAP} fecs_hstate_t;

	fecs_hstate_t hstate;
	logic [15:0] addr_reg;
	logic [1:0] cfg_reg;
	logic [15:0] rd_reg;
	logic [2:0] op;
	logic [2:0] idx;
	logic setup, mapped, cmd_wr;

	assign setup = psel_in && !penable_in;
	assign mapped = paddr_in == REG_CMD || paddr_in == REG_ADDR ||
		paddr_in == REG_CFG || paddr_in == REG_STATUS;
	assign cmd_wr = setup && pwrite_in && paddr_in == REG_CMD;

	// One write of a sequence: address and data for step k
	function automatic logic [31:0] step_word(input logic [2:0] o, input logic [2:0] k,
		input logic [15:0] a, input logic bm);
		logic [11:0] oa, ob;
		oa = bm ? BYTE_OFS_A : WORD_OFS_A;
		ob = bm ? BYTE_OFS_B : WORD_OFS_B;
		step_word = {a, CMD_READ_RESET};
		if (o == OP_SECTOR || o == OP_CHIP) begin
			unique case (k)
				3'h0, 3'h3: step_word = {a[15:12], oa, CMD_UNLOCK1};
				3'h1, 3'h4: step_word = {a[15:12], ob, CMD_UNLOCK2};
				3'h2: step_word = {a[15:12], oa, CMD_SETUP};
				default: step_word = (o == OP_CHIP) ? {a[15:12], oa, CMD_CHIP} :
					{a, CMD_SECTOR};
			endcase
		end else if (o == OP_ADD) begin
			step_word = {a, CMD_SECTOR};
		end else if (o == OP_SUSPEND) begin
			step_word = {a, CMD_SUSPEND};
		end else if (o == OP_RESUME) begin
			step_word = {a, CMD_RESUME};
		end
	endfunction : step_word

	// ************************************************************
	// APB slave, zero wait states
	// ************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			addr_reg <= '0;
			cfg_reg <= '0;
			prdata_out <= '0;
			pready_out <= 1'b1;
			pslverr_out <= 1'b0;
		end else if (setup) begin
			pslverr_out <= !mapped;
			prdata_out <= '0;
			if (pwrite_in && paddr_in == REG_ADDR) begin
				addr_reg <= pwdata_in[15:0];
			end
			if (pwrite_in && paddr_in == REG_CFG) begin
				cfg_reg <= pwdata_in[1:0];
			end
			if (!pwrite_in) begin
				unique case (paddr_in)
					REG_ADDR: prdata_out <= {16'h0000, addr_reg};
					REG_CFG: prdata_out <= {30'h0, cfg_reg};
					REG_STATUS: prdata_out <= {rd_reg, 15'h0, hstate != H_IDLE};
					default: prdata_out <= '0;
				endcase
			end
		end
	end

	// ************************************************************
	// Link sequencer
	// ************************************************************
	// Orders arriving while busy are dropped; software polls the busy bit
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hstate <= H_IDLE;
			op <= '0;
			idx <= '0;
			rd_reg <= '0;
			link.we_n <= 1'b1;
			link.oe_n <= 1'b1;
			link.addr <= '0;
			link.wdata <= '0;
		end else begin
			unique case (hstate)
				H_IDLE: if (cmd_wr && pwdata_in[2:0] != 3'h0) begin
					op <= pwdata_in[2:0];
					idx <= '0;
					if (pwdata_in[2:0] == OP_READ) begin
						hstate <= H_RLOW;
						link.addr <= addr_reg;
						link.oe_n <= 1'b0;
					end else begin
						hstate <= H_WLOW;
						{link.addr, link.wdata} <=
							step_word(pwdata_in[2:0], 3'h0, addr_reg, cfg_reg[CFG_BYTE_BIT]);
						link.we_n <= 1'b0;
					end
				end
				H_WLOW: begin
					hstate <= H_WHIGH;
					link.we_n <= 1'b1; // Device takes the write at this rise
				end
				H_WHIGH: begin
					if ((op == OP_SECTOR || op == OP_CHIP) && idx != SEQ_LEN - 3'h1) begin
						hstate <= H_WLOW;
						idx <= idx + 3'h1;
						{link.addr, link.wdata} <=
							step_word(op, idx + 3'h1, addr_reg, cfg_reg[CFG_BYTE_BIT]);
						link.we_n <= 1'b0;
					end else begin
						hstate <= H_IDLE;
					end
				end
				H_RLOW: hstate <= H_RCAP;
				H_RCAP: begin
					rd_reg <= link.rdata;
					link.oe_n <= 1'b1;
					hstate <= H_IDLE;
				end
			endcase
		end
	end

	// Mode and hardware reset lines follow the config register
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			link.byte_mode <= 1'b0;
			link.hw_reset_n <= 1'b1;
		end else begin
			link.byte_mode <= cfg_reg[CFG_BYTE_BIT];
			link.hw_reset_n <= !cfg_reg[CFG_HWRST_BIT];
		end
	end
endmodule : fecs_host

/* testbench/fecs_asserts.sv */
// Checker for the flash bus between the host end and the sequencer end.
// Assumes one clock for both ends; instantiated beside the interface.
`timescale 1ns/10ps
module fecs_asserts
	import fecs_pkg::*;
#(
	parameter int WINDOW_CYC = ERASE_ACCEPT_WINDOW_CYC,
	parameter int STEP_CYCLES = STEP_CYC
) (
	input wire logic clk_sys_in, // System clock
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic we_n_in, // Write strobe, active low
	input wire logic oe_n_in, // Read strobe, active low
	input wire logic [15:0] addr_in, // Flash address
	input wire logic [15:0] wdata_in, // Write data
	input wire logic [15:0] rdata_in, // Read data
	input wire logic byte_mode_in, // Byte addressing
	input wire logic hw_reset_n_in, // Hardware reset, active low
	input wire logic busy_in, // Sequencer busy
	input wire logic suspended_in // Erase suspended
);
	// ************************************************************
	// Busy length counter
	// ************************************************************
	// Window plus both walk phases, with a little slack for the status lag
	localparam int BUSY_MAX = WINDOW_CYC + 2 * NUM_WORDS * STEP_CYCLES + 8;
	int busy_cnt;

	// Any write may restart the window, so the count starts again there
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !busy_in || suspended_in || !we_n_in)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	// ************************************************************
	// Assertions
	// ************************************************************
	a_busy_bounded: assert property (busy_cnt <= BUSY_MAX)
		else $error("Busy outlasted window and walk");
	a_hwrst_busy: assert property (!hw_reset_n_in ##1 !hw_reset_n_in |=> !busy_in)
		else $error("Busy survived hardware reset");
	a_hwrst_susp: assert property (!hw_reset_n_in ##1 !hw_reset_n_in |=> !suspended_in)
		else $error("Suspend survived hardware reset");
	a_busy_start: assert property ($rose(busy_in) |->
		$past(we_n_in, 2) && !$past(we_n_in, 3))
		else $error("Busy rose without a finished write");
	a_susp_start: assert property ($rose(suspended_in) |->
		$past(we_n_in, 2) && !$past(we_n_in, 3))
		else $error("Suspend rose without a write");
	a_susp_idle: assert property (suspended_in |-> !busy_in)
		else $error("Busy while suspended");
	a_rdata_hold: assert property ($past(oe_n_in) |-> $stable(rdata_in))
		else $error("Read data moved without a read");
	a_we_pulse: assert property ($fell(we_n_in) |=> we_n_in)
		else $error("Write strobe low too long");
	a_write_hold: assert property (!we_n_in |=> $stable(addr_in) && $stable(wdata_in))
		else $error("Address or data moved at strobe rise");
	// The second unlock offset must follow the addressing mode
	a_unlock_ofs: assert property (!we_n_in && wdata_in == CMD_UNLOCK2 |->
		addr_in[11:0] == (byte_mode_in ? BYTE_OFS_B : WORD_OFS_B))
		else $error("Second unlock write at wrong offset");

	// Main scenarios
	c_suspend: cover property ($rose(suspended_in));
	c_done: cover property ($fell(busy_in));
	c_abort: cover property (busy_in && !hw_reset_n_in);
	c_byte_write: cover property (!we_n_in && byte_mode_in);
endmodule : fecs_asserts

/* testbench/fecs_bench.sv */
// Bench for host and sequencer ends joined by the flash bus interface.
// Assumes APB with zero wait states; drives APB only, reads status back.
`timescale 1ns/10ps
module fecs_bench;
	import fecs_pkg::*;
	// Short window keeps the run brief; walk steps are twice the default; figures below derive from them
	localparam int WIN_SIM = 40;
	localparam int STEP_SIM = 8;
	logic clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, busy, susp;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] st, st2;
	int num_errors = 0;
	int tests_run = 0;
	fecs_if link ();

	fecs_host u_fecs_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link));
	fecs_device #(.WINDOW_CYC(WIN_SIM), .STEP_CYCLES(STEP_SIM)) u_fecs_device (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(link), .busy_out(busy),
		.suspended_out(susp));
	fecs_asserts #(.WINDOW_CYC(WIN_SIM), .STEP_CYCLES(STEP_SIM)) u_fecs_asserts (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .we_n_in(link.we_n), .oe_n_in(link.oe_n),
		.addr_in(link.addr), .wdata_in(link.wdata), .rdata_in(link.rdata),
		.byte_mode_in(link.byte_mode), .hw_reset_n_in(link.hw_reset_n), .busy_in(busy),
		.suspended_in(susp));

	// ************************************************************
	// Tasks
	// ************************************************************
	task final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			final_report();
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	// Issue one order and poll until the host end is idle again
	task cmd(input logic [2:0] op, input logic [15:0] a, output logic [31:0] r);
		int n;
		wr(REG_ADDR, {16'h0000, a});
		wr(REG_CMD, {29'h00000000, op});
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h00000000, r);
			n++;
		end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 40);
		if (r[STAT_BUSY_BIT] !== 1'b0) begin
			num_errors++;
			final_report();
		end
	endtask : cmd

	task rd(input logic [15:0] a, output logic [15:0] d);
		logic [31:0] r;
		cmd(OP_READ, a, r);
		d = r[31:16];
	endtask : rd

	task wait_idle;
		int n;
		for (n = 0; n < 2000 && busy !== 1'b0; n++)
			@(posedge clk_sys_in);
		if (busy !== 1'b0) begin
			num_errors++;
			final_report();
		end
	endtask : wait_idle

	// ************************************************************
	// Clock and sequence
	// ************************************************************
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	initial begin
		rst_in = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		// Register readback and an unmapped place
		wr(REG_ADDR, 32'h00001234);
		apb(1'b0, REG_ADDR, 32'h00000000, q);
		chk(q[15:0], 16'h1234);
		chk(pslverr, 1'b0);
		apb(1'b0, 12'h010, 32'h00000000, q);
		chk(q, 32'h00000000);
		chk(pslverr, 1'b1);
		// Foreign command inside the window drops back to reads
		cmd(OP_SECTOR, 16'h2000, q);
		chk(busy, 1'b1);
		cmd(OP_RESET_CMD, 16'h2000, q);
		chk(busy, 1'b0);
		rd(16'h2000, st);
		chk(st, ERASED_WORD);
		// Suspend inside the window, then resume to completion
		cmd(OP_SECTOR, 16'hC000, q);
		cmd(OP_SUSPEND, 16'hC000, q);
		chk(susp, 1'b1);
		chk(busy, 1'b0);
		rd(16'h0000, st);
		chk(st, ERASED_WORD);
		rd(16'hC000, st);
		chk(st[DP_BIT], 1'b1);
		cmd(OP_RESUME, 16'hC000, q);
		wait_idle();
		chk(susp, 1'b0);
		rd(16'hC001, st);
		chk(st, ERASED_WORD);
		// Two sectors queued out of order, status polled, then aborted
		cmd(OP_SECTOR, 16'hA000, q);
		cmd(OP_ADD, 16'h8000, q);
		rd(16'hA000, st);
		chk(st & 16'hFFBB, 16'h0000);
		rd(16'hA000, st2);
		chk((st ^ st2) & 16'h0044, 16'h0044);
		rd(16'h0002, st);
		chk(st, ERASED_WORD);
		for (int n = 0; n < 20 && st2[WIN_BIT] !== 1'b1; n++)
			rd(16'hA000, st2);
		chk(st2[WIN_BIT], 1'b1);
		cmd(OP_RESET_CMD, 16'hA000, q);
		chk(busy, 1'b1);
		// Lands after both sectors are zeroed and before their erase begins
		repeat (220) @(posedge clk_sys_in);
		wr(REG_CFG, 32'h00000002);
		wr(REG_CFG, 32'h00000000);
		chk(busy, 1'b0);
		rd(16'hA000, st);
		chk(st, PREPROG_WORD);
		rd(16'h8003, st);
		chk(st, PREPROG_WORD);
		// Chip erase in byte mode; suspend must change nothing
		wr(REG_CFG, 32'h00000001);
		apb(1'b0, REG_CFG, 32'h00000000, q);
		chk(q, 32'h00000001);
		cmd(OP_CHIP, 16'h0000, q);
		chk(busy, 1'b1);
		cmd(OP_SUSPEND, 16'h0000, q);
		chk(susp, 1'b0);
		chk(busy, 1'b1);
		wait_idle();
		wr(REG_CFG, 32'h00000000);
		rd(16'hA000, st);
		chk(st, ERASED_WORD);
		rd(16'h8003, st);
		chk(st, ERASED_WORD);
		final_report();
	end
endmodule : fecs_bench
